// ===== core/fsp_pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module fsp_pin_sync #(
	parameter int              WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             ref_clk_i,
	input  wire logic             resetn_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] level_o
);

	logic [3:0][WIDTH-1:0] st;
	logic [3:0][WIDTH-1:0] next_st;

	// ------------------------------------------------------------------
	// Per bit: three-stage shift; st[3] follows st[2] only while st[1] and st[2] agree
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_comb begin
				next_st[0][g] = async_i[g];
				next_st[1][g] = st[0][g];
				next_st[2][g] = st[1][g];
				next_st[3][g] = (st[1][g] == st[2][g]) ? st[2][g]
					: st[3][g];
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st <= {INIT, INIT, INIT, INIT};
		end else begin
			st <= next_st;
		end
	end

	assign level_o = st[3];

endmodule

// ===== core/fsp_pkg.sv
// Package: constants and carrier types of the fuse and programming port
package fsp_pkg;

	// ------------------------------------------------------------------
	// Clock and operation times
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int PULSE_MIN_NS  = 250;
	localparam int PULSE_MIN_CYC =
		(PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_NS       = 1000;
	localparam int ERASE_NS      = 4000;
	localparam int CNT_W         = 10;
	localparam logic [CNT_W-1:0] PROG_CYC =
		CNT_W'((PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] ERASE_CYC =
		CNT_W'((ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ------------------------------------------------------------------
	// Fuse defaults and field positions (0 = programmed)
	// ------------------------------------------------------------------
	localparam logic [7:0] EXT_DEFAULT  = 8'hFF;
	localparam logic [7:0] HIGH_DEFAULT = 8'h99;
	localparam logic [7:0] LOW_DEFAULT  = 8'h62;
	localparam logic [7:0] LOCK_DEFAULT = 8'hFF;
	localparam logic [7:0] EXT_UNUSED   = 8'hF8;
	localparam logic [7:0] LOCK_UNUSED  = 8'hC0;
	localparam int BOD_LSB    = 0;
	localparam int OCD_POS    = 7;
	localparam int SCAN_POS   = 6;
	localparam int SPROG_POS  = 5;
	localparam int WDT_POS    = 4;
	localparam int KEEP_POS   = 3;
	localparam int BOOTSZ_LSB = 1;
	localparam int BOOTV_POS  = 0;
	localparam int DIV8_POS   = 7;
	localparam int CKRT_POS   = 6;
	localparam int SUT_LSB    = 4;
	localparam int CLK_SOURCE_SEL_LSB  = 0;
	localparam int LB1_POS    = 0;

	// ------------------------------------------------------------------
	// Identification and calibration (values arbitrary)
	// ------------------------------------------------------------------
	localparam logic [7:0] IDENT_ZERO = 8'h5A;
	localparam logic [7:0] IDENT_ONE  = 8'h3C;
	localparam logic [7:0] IDENT_TWO  = 8'h71;
	localparam logic [7:0] CAL_BYTE   = 8'h80;
	localparam logic [7:0] IDENT_BYTE_ZERO_OFS = 8'h00;
	localparam logic [7:0] IDENT_BYTE_ONE_OFS  = 8'h01;
	localparam logic [7:0] IDENT_BYTE_TWO_OFS  = 8'h02;
	localparam logic [7:0] BLANK_BYTE          = 8'hFF;

	// ------------------------------------------------------------------
	// Memory geometry
	// ------------------------------------------------------------------
	localparam int WORD_LSB = 0;
	localparam int WORD_W   = 7;
	localparam int PAGE_LSB = 7;
	localparam int PAGE_W   = 10;
	localparam int EEB_LSB  = 0;
	localparam int EEB_W    = 3;
	localparam int EEP_LSB  = 3;
	localparam int EEP_W    = 9;

	// ------------------------------------------------------------------
	// Pin encodings
	// ------------------------------------------------------------------
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	localparam logic [1:0] SEL_LOW  = 2'h0;
	localparam logic [1:0] SEL_HIGH = 2'h1;
	localparam logic [1:0] SEL_EXT  = 2'h2;
	localparam logic [1:0] SEL_ALT  = 2'h3;
	localparam logic [7:0] CMD_ERASE    = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EE    = 8'h11;
	localparam logic [7:0] CMD_RD_SIG   = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_EE    = 8'h03;

	typedef enum logic {OP_IDLE, OP_BUSY} fsp_op_e;

	typedef struct packed {
		logic [7:0] ext;
		logic [7:0] high;
		logic [7:0] low;
	} fsp_fuse_s;

	typedef struct packed {
		logic [2:0] brownout_threshold;
		logic       onchip_debug_fuse;
		logic       scan_port_fuse;
		logic       serial_prog_fuse;
		logic       watchdog_forced_on;
		logic [1:0] boot_area_size;
		logic       boot_vector_sel;
		logic       clk_div_eight_fuse;
		logic       clock_route_fuse;
		logic [1:0] startup_time_sel;
		logic [3:0] clk_source_sel;
	} fsp_cfg_s;

	// Pins passed through the synchroniser as one bundle
	typedef struct packed {
		logic       prog_mode;
		logic       serial_mode;
		logic       step_clock;
		logic [1:0] pulse_action;
		logic [1:0] byte_sel;
		logic       program_strobe_n;
		logic       read_drive_n;
		logic       page_latch;
		logic [7:0] data;
	} fsp_pins_s;

	localparam int PINS_W = $bits(fsp_pins_s);
	localparam logic [PINS_W-1:0] PINS_IDLE = {2'h0, 1'h0, 4'h0,
		1'h1, 1'h1, 1'h0, 8'h00};

endpackage

// ===== core/fsp_prog_port.sv
// Fuse store, signature space and parallel programming port
//
// Summary of operation
// - Three fuse bytes held; a programmed bit reads 0, unprogrammed 1.
// - Extended byte: bits 7..3 unused at 1, bits 2..0 brownout level.
// - High byte: bit7 debug off, bit6 scan on, bit5 serial prog on.
// - High byte: bit4 watchdog forced, bit3 keep data; both off.
// - High byte: boot size bits 2:1 programmed, vector bit 0 not.
// - Serial programming fuse cannot change while in serial mode.
// - Low byte: start-up bits 5:4 = 10, clock source = 0010.
// - Chip erase leaves every fuse bit as it was.
// - Programmed lock bit one refuses any further fuse change.
// - Fuses captured at mode entry; new values apply after exit.
// - Keep-data fuse acts at once when programmed.
// - Fuses also captured at power-up in normal mode.
// - Three identification bytes at signature addresses 0 to 2.
// - Calibration byte copied to the trim register at every reset.
// - Flash: word bits 6:0, page bits 16:7 of the address.
// - EEPROM: byte bits 2:0, page bits 11:3 of the address.
// - Rising step clock performs the action the action bits select.
// - Low strobe or read pulse runs the last loaded command.
// - Ready output low while an operation runs, high otherwise.
// - Data bus driven only while the synchronised read pin is low.
// - Action codes: 00 address, 01 data, 10 command, 11 none.
// - Byte select: 00 low, 01 high, 10 extended; fuse readback 01 lock, 11 high.
// - Command byte encodings for erase, writes and reads.
`timescale 1ns/1ns
module fsp_prog_port
	import fsp_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       prog_mode_i,
	input  wire logic       serial_mode_i,
	input  wire logic       step_clock_pin_i,
	input  wire logic       pulse_action_b0_i,
	input  wire logic       pulse_action_b1_i,
	input  wire logic       byte_sel_lo_i,
	input  wire logic       byte_sel_hi_i,
	input  wire logic       program_strobe_n_i,
	input  wire logic       read_drive_n_i,
	input  wire logic       page_latch_pulse_i,
	input  wire logic [7:0] data_i,
	output logic      [7:0] data_o,
	output logic            data_oe_o,
	output logic            ready_not_busy_o,
	output fsp_fuse_s       fuse_active_o,
	output fsp_cfg_s        cfg_o,
	output logic            keep_nvdata_on_erase_o,
	output logic      [7:0] rc_trim_reg_o,
	output logic      [7:0] lock_byte_o,
	output logic      [WORD_W-1:0] word_in_page_bits_o,
	output logic      [PAGE_W-1:0] page_index_bits_o,
	output logic      [EEB_W-1:0]  nv_byte_addr_o,
	output logic      [EEP_W-1:0]  nv_page_addr_o,
	output logic      [15:0]       prog_word_o,
	output logic            flash_write_o,
	output logic            eeprom_write_o,
	output logic            page_load_o,
	output logic            chip_erase_o
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		fsp_op_e          op;
		logic [CNT_W-1:0] cnt;
		logic             boot;
		logic             prog_q;
		logic             step_q;
		logic             wr_q;
		logic             page_latch_pulse_q;
		logic [7:0]       cmd;
		logic [7:0]       addr_lo;
		logic [7:0]       addr_hi;
		logic [7:0]       addr_ext;
		logic [7:0]       data_lo;
		logic [7:0]       data_hi;
		fsp_fuse_s        nv;
		fsp_fuse_s        act;
		logic [7:0]       lock;
		logic [7:0]       trim;
		logic             keep;
		logic [7:0]       dout;
		logic             doe;
		logic             rdy;
		logic             fl_wr;
		logic             ee_wr;
		logic             pg_ld;
		logic             erase;
	} fsp_state_s;

	fsp_state_s st;
	fsp_state_s next_st;
	fsp_pins_s  pins_async;
	fsp_pins_s  pin;
	logic [23:0] adr_q;

	localparam fsp_fuse_s FUSE_DEFAULT = '{EXT_DEFAULT, HIGH_DEFAULT,
		LOW_DEFAULT};

	// ------------------------------------------------------------------
	// Decoders
	// ------------------------------------------------------------------
	function automatic logic fuses_locked(input logic [7:0] lock);
		return !lock[LB1_POS];
	endfunction

	function automatic logic [23:0] full_addr(input fsp_state_s s);
		return {s.addr_ext, s.addr_hi, s.addr_lo};
	endfunction

	// ------------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------------
	always_comb begin
		pins_async.prog_mode        = prog_mode_i;
		pins_async.serial_mode      = serial_mode_i;
		pins_async.step_clock       = step_clock_pin_i;
		pins_async.pulse_action     = {pulse_action_b1_i,
			pulse_action_b0_i};
		pins_async.byte_sel         = {byte_sel_hi_i, byte_sel_lo_i};
		pins_async.program_strobe_n = program_strobe_n_i;
		pins_async.read_drive_n     = read_drive_n_i;
		pins_async.page_latch       = page_latch_pulse_i;
		pins_async.data             = data_i;
	end

	fsp_pin_sync #(
		.WIDTH (PINS_W),
		.INIT  (PINS_IDLE)
	) u_sync (
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.async_i   (pins_async),
		.level_o   (pin)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic step_rise;
		logic wr_fall;
		logic page_latch_pulse_rise;
		logic in_prog;
		logic [7:0] wbyte;
		in_prog    = pin.prog_mode;
		step_rise  = in_prog && pin.step_clock && !st.step_q;
		wr_fall    = in_prog && !pin.program_strobe_n && st.wr_q;
		page_latch_pulse_rise = in_prog && pin.page_latch && !st.page_latch_pulse_q;
		wbyte      = 8'h00;
		next_st    = st;

		next_st.prog_q  = pin.prog_mode;
		next_st.step_q  = pin.step_clock;
		next_st.wr_q    = pin.program_strobe_n;
		next_st.page_latch_pulse_q = pin.page_latch;
		next_st.fl_wr   = 1'b0;
		next_st.ee_wr   = 1'b0;
		next_st.pg_ld   = 1'b0;
		next_st.erase   = 1'b0;

		// Power-up capture, then on mode entry and exit
		if (st.boot) begin
			next_st.boot = 1'b0;
			next_st.act  = st.nv;
		end else if (pin.prog_mode != st.prog_q) begin
			next_st.act = st.nv;
		end

		// Loads on the rising step clock
		if (step_rise) begin
			unique case (pin.pulse_action)
				ACT_ADDR: begin
					unique case (pin.byte_sel)
						SEL_LOW:  next_st.addr_lo  = pin.data;
						SEL_HIGH: next_st.addr_hi  = pin.data;
						SEL_EXT:  next_st.addr_ext = pin.data;
						SEL_ALT:  ;
					endcase
				end
				ACT_DATA: begin
					if (pin.byte_sel[0]) begin
						next_st.data_hi = pin.data;
					end else begin
						next_st.data_lo = pin.data;
					end
				end
				ACT_CMD:  next_st.cmd = pin.data;
				default:  ;
			endcase
		end

		if (page_latch_pulse_rise) begin
			next_st.pg_ld = 1'b1;
		end

		// Write strobe; refused while busy
		unique case (st.op)
			OP_IDLE: begin
				if (wr_fall) begin
					unique case (st.cmd)
						CMD_ERASE: begin
							// Fuses untouched by erase
							next_st.lock  = LOCK_DEFAULT;
							next_st.erase = 1'b1;
							next_st.cnt   = ERASE_CYC;
							next_st.op    = OP_BUSY;
						end
						CMD_WR_FUSE: begin
							if (!fuses_locked(st.lock)) begin
								wbyte = st.data_lo;
								unique case (pin.byte_sel)
									SEL_LOW: next_st.nv.low = wbyte;
									SEL_HIGH: begin
										if (pin.serial_mode) begin
											wbyte[SPROG_POS] =
												st.nv.high[SPROG_POS];
										end
										next_st.nv.high = wbyte;
										next_st.keep    =
											!wbyte[KEEP_POS];
									end
									SEL_EXT: next_st.nv.ext =
										wbyte | EXT_UNUSED;
									SEL_ALT: ;
								endcase
								next_st.cnt = PROG_CYC;
								next_st.op  = OP_BUSY;
							end
						end
						CMD_WR_LOCK: begin
							// Lock bits only go to programmed here
							next_st.lock = st.lock & (st.data_lo
								| LOCK_UNUSED);
							next_st.cnt  = PROG_CYC;
							next_st.op   = OP_BUSY;
						end
						CMD_WR_FLASH, CMD_WR_EE: begin
							if (!fuses_locked(st.lock)) begin
								next_st.fl_wr = (st.cmd == CMD_WR_FLASH);
								next_st.ee_wr = (st.cmd == CMD_WR_EE);
								next_st.cnt   = PROG_CYC;
								next_st.op    = OP_BUSY;
							end
						end
						default: ;
					endcase
				end
			end
			OP_BUSY: begin
				next_st.cnt = st.cnt - CNT_W'(1);
				if (st.cnt == CNT_W'(1)) begin
					next_st.op = OP_IDLE;
				end
			end
		endcase
		next_st.rdy = (next_st.op == OP_IDLE);

		// Readback while the read pin is low
		next_st.doe  = in_prog && !pin.read_drive_n;
		next_st.dout = st.dout;
		if (in_prog && !pin.read_drive_n) begin
			unique case (st.cmd)
				CMD_RD_SIG: begin
					if (pin.byte_sel[0]) begin
						next_st.dout = st.trim;
					end else begin
						unique case (st.addr_lo)
							IDENT_BYTE_ZERO_OFS: next_st.dout = IDENT_ZERO;
							IDENT_BYTE_ONE_OFS:  next_st.dout = IDENT_ONE;
							IDENT_BYTE_TWO_OFS:  next_st.dout = IDENT_TWO;
							default:             next_st.dout = BLANK_BYTE;
						endcase
					end
				end
				CMD_RD_FUSE: begin
					unique case (pin.byte_sel)
						SEL_LOW:  next_st.dout = st.nv.low;
						SEL_HIGH: next_st.dout = st.lock;
						SEL_EXT:  next_st.dout = st.nv.ext;
						SEL_ALT:  next_st.dout = st.nv.high;
					endcase
				end
				default: next_st.dout = BLANK_BYTE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st          <= '0;
			st.op       <= OP_IDLE;
			st.boot     <= 1'b1;
			st.wr_q     <= 1'b1;
			st.nv       <= FUSE_DEFAULT;
			st.act      <= FUSE_DEFAULT;
			st.lock     <= LOCK_DEFAULT;
			st.trim     <= CAL_BYTE;
			st.keep     <= !HIGH_DEFAULT[KEEP_POS];
			st.dout     <= BLANK_BYTE;
			st.rdy      <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all slices of registers
	// ------------------------------------------------------------------
	assign data_o                 = st.dout;
	assign data_oe_o              = st.doe;
	assign ready_not_busy_o       = st.rdy;
	assign fuse_active_o          = st.act;
	assign keep_nvdata_on_erase_o = st.keep;
	assign rc_trim_reg_o          = st.trim;
	assign lock_byte_o            = st.lock;
	assign prog_word_o            = {st.data_hi, st.data_lo};
	assign flash_write_o          = st.fl_wr;
	assign eeprom_write_o         = st.ee_wr;
	assign page_load_o            = st.pg_ld;
	assign chip_erase_o           = st.erase;

	assign adr_q               = full_addr(st);
	assign word_in_page_bits_o = adr_q[WORD_LSB +: WORD_W];
	assign page_index_bits_o   = adr_q[PAGE_LSB +: PAGE_W];
	assign nv_byte_addr_o      = adr_q[EEB_LSB +: EEB_W];
	assign nv_page_addr_o      = adr_q[EEP_LSB +: EEP_W];

	assign cfg_o.brownout_threshold = st.act.ext[BOD_LSB +: 3];
	assign cfg_o.onchip_debug_fuse  = st.act.high[OCD_POS];
	assign cfg_o.scan_port_fuse     = st.act.high[SCAN_POS];
	assign cfg_o.serial_prog_fuse   = st.act.high[SPROG_POS];
	assign cfg_o.watchdog_forced_on = st.act.high[WDT_POS];
	assign cfg_o.boot_area_size     = st.act.high[BOOTSZ_LSB +: 2];
	assign cfg_o.boot_vector_sel    = st.act.high[BOOTV_POS];
	assign cfg_o.clk_div_eight_fuse = st.act.low[DIV8_POS];
	assign cfg_o.clock_route_fuse   = st.act.low[CKRT_POS];
	assign cfg_o.startup_time_sel   = st.act.low[SUT_LSB +: 2];
	assign cfg_o.clk_source_sel     = st.act.low[CLK_SOURCE_SEL_LSB +: 4];

endmodule

// ===== sim/fsp_prog_model.sv
// Programmer model: drives the parallel programming pins
`timescale 1ns/1ns
module fsp_prog_model
	import fsp_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       ready_i,
	input  wire logic [7:0] bus_i,
	output logic            step_o,
	output logic [1:0]      act_o,
	output logic [1:0]      sel_o,
	output logic            strobe_n_o,
	output logic            read_n_o,
	output logic            latch_o,
	output logic [7:0]      drv_o
);
	initial begin
		step_o     = 1'b0;
		act_o      = 2'h3;
		sel_o      = 2'h0;
		strobe_n_o = 1'b1;
		read_n_o   = 1'b1;
		latch_o    = 1'b0;
		drv_o      = 8'h00;
	end

	// Setup, pulse and gap all exceed the minimum width
	task automatic hold;
		repeat (PULSE_MIN_CYC + 1) @(posedge ref_clk_i);
	endtask

	task automatic step(input logic [1:0] a, input logic [1:0] s,
		input logic [7:0] d);
		act_o <= a;
		sel_o <= s;
		drv_o <= d;
		hold();
		step_o <= 1'b1;
		hold();
		step_o <= 1'b0;
		act_o  <= 2'h3;
		hold();
	endtask

	// Counts busy cycles; returns once ready is back, or after 1300 cycles if busy never starts
	task automatic write(input logic [1:0] s, output int n);
		n = 0;
		sel_o <= s;
		hold();
		strobe_n_o <= 1'b0;
		for (int i = 0; i < 1300; i++) begin
			@(posedge ref_clk_i);
			if (i == PULSE_MIN_CYC) strobe_n_o <= 1'b1;
			if (ready_i !== 1'b1) n++;
			if (n > 0 && ready_i === 1'b1 && i > PULSE_MIN_CYC) break;
		end
	endtask

	task automatic read(input logic [1:0] s, output logic [7:0] d);
		sel_o <= s;
		hold();
		read_n_o <= 1'b0;
		drv_o    <= ~drv_o;
		hold();
		d = bus_i;
		read_n_o <= 1'b1;
		hold();
	endtask

	task automatic latch;
		latch_o <= 1'b1;
		hold();
		latch_o <= 1'b0;
		hold();
	endtask
endmodule

// ===== sim/fsp_prog_port_chk.sv
// Checker: output timing and fuse relations of the programming port
`timescale 1ns/1ns
module fsp_prog_port_chk
	import fsp_pkg::*;
(
	input wire logic       ref_clk_i,
	input wire logic       resetn_i,
	input wire logic       prog_mode_i,
	input wire logic       read_drive_n_i,
	input wire logic       program_strobe_n_i,
	input wire logic       data_oe_o,
	input wire logic       ready_not_busy_o,
	input wire fsp_fuse_s  fuse_active_o,
	input wire fsp_cfg_s   cfg_o,
	input wire logic [7:0] rc_trim_reg_o,
	input wire logic [7:0] lock_byte_o,
	input wire logic       flash_write_o,
	input wire logic       chip_erase_o
);
	// ----------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------
	logic [10:0] busy_cnt;
	logic [3:0]  rel_cnt;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_cnt <= 11'h000;
			rel_cnt  <= 4'hF;
		end else begin
			busy_cnt <= ready_not_busy_o ? 11'h000 : busy_cnt + 11'h001;
			if (!read_drive_n_i) begin
				rel_cnt <= 4'h0;
			end else if (rel_cnt != 4'hF) begin
				rel_cnt <= rel_cnt + 4'h1;
			end
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	// Sync lag lets the drive outlast the read pin by a few cycles only
	a_oe_read_only: assert property (data_oe_o |-> rel_cnt < 4'h8)
		else $error("data bus driven long after read pin release");
	a_busy_cause: assert property ($fell(ready_not_busy_o) |->
		!$past(program_strobe_n_i, 3))
		else $error("busy started without a write strobe");
	a_busy_hold: assert property ($fell(ready_not_busy_o) |=>
		!ready_not_busy_o [*8])
		else $error("busy shorter than eight cycles");
	a_busy_bound: assert property (busy_cnt <= 11'h3F2)
		else $error("busy lasted too long");
	a_erase_busy: assert property (chip_erase_o |->
		##[0:1] !ready_not_busy_o)
		else $error("erase pulse without busy");
	a_flash_pulse: assert property (flash_write_o |=> !flash_write_o)
		else $error("flash write pulse longer than one cycle");
	a_lock_blocks: assert property (!lock_byte_o[0] |-> !flash_write_o)
		else $error("flash write while locked");
	a_ext_unused: assert property (fuse_active_o.ext[7:3] == 5'h1F)
		else $error("unused extended fuse bits not one");
	a_cfg_slices: assert property (
		cfg_o.clk_source_sel == fuse_active_o.low[3:0] &&
		cfg_o.serial_prog_fuse == fuse_active_o.high[5])
		else $error("config fields differ from active fuses");
	a_active_hold: assert property ($stable(prog_mode_i) [*8] |=>
		$stable(fuse_active_o))
		else $error("active fuses changed without mode change");
	a_trim_copy: assert property (rc_trim_reg_o == CAL_BYTE)
		else $error("trim register differs from calibration byte");
endmodule

bind fsp_prog_port fsp_prog_port_chk chk (
	.ref_clk_i          (ref_clk_i),
	.resetn_i           (resetn_i),
	.prog_mode_i        (prog_mode_i),
	.read_drive_n_i     (read_drive_n_i),
	.program_strobe_n_i (program_strobe_n_i),
	.data_oe_o          (data_oe_o),
	.ready_not_busy_o   (ready_not_busy_o),
	.fuse_active_o      (fuse_active_o),
	.cfg_o              (cfg_o),
	.rc_trim_reg_o      (rc_trim_reg_o),
	.lock_byte_o        (lock_byte_o),
	.flash_write_o      (flash_write_o),
	.chip_erase_o       (chip_erase_o)
);

// ===== sim/fsp_prog_port_tb.sv
// Testbench: fuse store and parallel programming port
`timescale 1ns/1ns
module fsp_prog_port_tb;
	import fsp_pkg::*;
	logic ref_clk_i, resetn_i, prog_mode, serial_mode;
	logic step, strobe_n, read_n, latch, data_oe, ready, keep, fw, ew, pl;
	logic [1:0] act, sel;
	logic [7:0] drv, bus, dut_data, trim, lock;
	fsp_fuse_s  fuse;
	fsp_cfg_s   cfg;
	logic [6:0] word;
	logic [9:0] page;
	logic [2:0] nvb;
	logic [8:0] nvp;
	logic [15:0] pword;
	int n_mismatch = 0;
	int n_tests = 0;
	int n_fw = 0, n_ew = 0, n_pl = 0;

	assign bus = data_oe ? dut_data : drv;

	fsp_prog_model prg (
		.ref_clk_i  (ref_clk_i),
		.ready_i    (ready),
		.bus_i      (bus),
		.step_o     (step),
		.act_o      (act),
		.sel_o      (sel),
		.strobe_n_o (strobe_n),
		.read_n_o   (read_n),
		.latch_o    (latch),
		.drv_o      (drv)
	);

	fsp_prog_port dut (
		.ref_clk_i (ref_clk_i),
		.resetn_i (resetn_i),
		.prog_mode_i (prog_mode),
		.serial_mode_i (serial_mode),
		.step_clock_pin_i (step),
		.pulse_action_b0_i (act[0]),
		.pulse_action_b1_i (act[1]),
		.byte_sel_lo_i (sel[0]),
		.byte_sel_hi_i (sel[1]),
		.program_strobe_n_i (strobe_n),
		.read_drive_n_i (read_n),
		.page_latch_pulse_i (latch),
		.data_i (bus),
		.data_o (dut_data),
		.data_oe_o (data_oe),
		.ready_not_busy_o (ready),
		.fuse_active_o (fuse),
		.cfg_o (cfg),
		.keep_nvdata_on_erase_o (keep),
		.rc_trim_reg_o (trim),
		.lock_byte_o (lock),
		.word_in_page_bits_o (word),
		.page_index_bits_o (page),
		.nv_byte_addr_o (nvb),
		.nv_page_addr_o (nvp),
		.prog_word_o (pword),
		.flash_write_o (fw),
		.eeprom_write_o (ew),
		.page_load_o (pl),
		.chip_erase_o ()
	);

	always @(posedge ref_clk_i) begin
		n_fw <= n_fw + int'(fw === 1'b1);
		n_ew <= n_ew + int'(ew === 1'b1);
		n_pl <= n_pl + int'(pl === 1'b1);
	end

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic busy(input int n, input int cyc);
		check(32'(n >= cyc - 2 && n <= cyc + 2), 32'h1);
	endtask

	task automatic rd_fuse(input logic [1:0] s, input logic [7:0] exp);
		logic [7:0] d;
		prg.step(ACT_CMD, SEL_LOW, CMD_RD_FUSE);
		prg.read(s, d);
		check(d, exp);
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_defaults;
		check(fuse.ext, 8'hFF);
		check(fuse.high, 8'h99);
		check(fuse.low, 8'h62);
		check(cfg.clk_source_sel, 4'h2);
		check(trim, CAL_BYTE);
		check({ready, data_oe}, 2'h2);
		$display("defaults done");
	endtask

	task automatic t_sig;
		logic [7:0] d;
		logic [7:0] ids [3];
		ids = '{IDENT_ZERO, IDENT_ONE, IDENT_TWO};
		prg.step(ACT_CMD, SEL_LOW, CMD_RD_SIG);
		for (int i = 0; i < 3; i++) begin
			prg.step(ACT_ADDR, SEL_LOW, 8'(i));
			prg.read(SEL_LOW, d);
			check(d, ids[i]);
		end
		prg.read(SEL_HIGH, d);
		check(d, CAL_BYTE);
		for (int i = 0; i < 4; i++) begin
			rd_fuse(2'(i), 8'(32'h99FFFF62 >> 8*i));
		end
		$display("signature done");
	endtask

	task automatic t_fuse;
		int n;
		prg.step(ACT_CMD, SEL_LOW, CMD_WR_FUSE);
		serial_mode <= 1'b1;
		prg.step(ACT_DATA, SEL_LOW, 8'h3F);
		prg.write(SEL_HIGH, n);
		busy(n, PROG_CYC);
		serial_mode <= 1'b0;
		prg.step(ACT_DATA, SEL_LOW, 8'h05);
		prg.write(SEL_EXT, n);
		rd_fuse(SEL_ALT, 8'h1F);
		rd_fuse(SEL_EXT, 8'hFD);
		prg.step(ACT_CMD, SEL_LOW, CMD_WR_FUSE);
		prg.step(ACT_DATA, SEL_LOW, 8'h97);
		prg.write(SEL_HIGH, n);
		check(keep, 1'b1);
		check(fuse.high, 8'h99);
		prog_mode <= 1'b0;
		repeat (16) @(posedge ref_clk_i);
		check(fuse.high, 8'h97);
		check(fuse.ext, 8'hFD);
		prog_mode <= 1'b1;
		repeat (16) @(posedge ref_clk_i);
		$display("fuse write done");
	endtask

	task automatic t_flash;
		logic [7:0] d;
		int n;
		prg.step(ACT_CMD, SEL_LOW, CMD_WR_FLASH);
		prg.step(ACT_ADDR, SEL_LOW, 8'hFF);
		prg.step(ACT_ADDR, SEL_HIGH, 8'h83);
		prg.step(ACT_ADDR, SEL_EXT, 8'h01);
		prg.step(ACT_DATA, SEL_LOW, 8'h34);
		prg.step(ACT_DATA, SEL_HIGH, 8'h12);
		prg.latch();
		check({word, page}, {7'h7F, 10'h307});
		check({nvb, nvp}, {3'h7, 9'h07F});
		check(pword, 16'h1234);
		check(n_pl, 1);
		prg.write(SEL_LOW, n);
		busy(n, PROG_CYC);
		check(n_fw, 1);
		prg.step(ACT_CMD, SEL_LOW, CMD_WR_EE);
		prg.write(SEL_LOW, n);
		busy(n, PROG_CYC);
		check(n_ew, 1);
		prg.step(ACT_CMD, SEL_LOW, CMD_RD_FLASH);
		prg.read(SEL_LOW, d);
		check(d, BLANK_BYTE);
		prg.step(ACT_CMD, SEL_LOW, CMD_RD_EE);
		prg.read(SEL_LOW, d);
		check(d, BLANK_BYTE);
		$display("flash done");
	endtask

	task automatic t_erase;
		int n;
		prg.step(ACT_CMD, SEL_LOW, CMD_ERASE);
		prg.write(SEL_LOW, n);
		busy(n, ERASE_CYC);
		rd_fuse(SEL_ALT, 8'h97);
		rd_fuse(SEL_EXT, 8'hFD);
		check(keep, 1'b1);
		$display("erase done");
	endtask

	task automatic t_lock;
		int n;
		prg.step(ACT_CMD, SEL_LOW, CMD_WR_LOCK);
		prg.step(ACT_DATA, SEL_LOW, 8'hFE);
		prg.write(SEL_LOW, n);
		rd_fuse(SEL_HIGH, 8'hFE);
		check(lock, 8'hFE);
		prg.step(ACT_CMD, SEL_LOW, CMD_WR_FUSE);
		prg.step(ACT_DATA, SEL_LOW, 8'h00);
		prg.write(SEL_LOW, n);
		check(n, 0);
		rd_fuse(SEL_LOW, 8'h62);
		prg.step(ACT_CMD, SEL_LOW, CMD_WR_FLASH);
		prg.write(SEL_LOW, n);
		check(n_fw, 1);
		$display("lock done");
	endtask

	// ----------------------------------------------------------------
	// Clock, sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	initial begin
		resetn_i    = 1'b0;
		prog_mode   = 1'b0;
		serial_mode = 1'b0;
		repeat (8) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		t_defaults();
		prog_mode <= 1'b1;
		repeat (16) @(posedge ref_clk_i);
		t_sig();
		t_fuse();
		t_flash();
		t_erase();
		t_lock();
		give_verdict();
	end

	// Full sequence needs about 15500 cycles
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		n_mismatch++;
		give_verdict();
	end
endmodule
